// ==== hdl/input_format_pkg.sv ====
// Constants, field layouts and types shared by the input select/format block
package input_format_pkg;

	localparam int unsigned NUM_INPUTS   = 4;
	localparam int unsigned BUS_WIDTH    = 17;
	localparam int unsigned MANT_WIDTH   = 16;
	localparam int unsigned EXP_WIDTH    = 4;
	localparam int unsigned DATA_WIDTH   = 16;
	localparam int unsigned ADDR_WIDTH   = 3;
	localparam int unsigned MUX_DEPTH    = 8;

	// Register offsets
	localparam logic [2:0] CFG_A_OFFSET  = 3'h0;
	localparam logic [2:0] CFG_B_OFFSET  = 3'h1;
	localparam logic [2:0] CFG_C_OFFSET  = 3'h2;
	localparam logic [2:0] CFG_D_OFFSET  = 3'h3;
	localparam logic [2:0] ROUTE_OFFSET  = 3'h4;
	localparam logic [2:0] STATUS_OFFSET = 3'h5;

	// Input configuration field positions
	localparam int unsigned FALL_BIT     = 0;
	localparam int unsigned OWNCLK_BIT   = 1;
	localparam int unsigned IGNEXP_BIT   = 3;
	localparam int unsigned REV_BIT      = 4;
	localparam int unsigned OFFBIN_BIT   = 5;
	localparam int unsigned FMT_LSB      = 6;
	localparam int unsigned MODE_LSB     = 8;
	localparam int unsigned DELAY_LSB    = 10;
	localparam int unsigned RANGE_LSB    = 13;

	// Values after reset, and fill for unused status bits
	localparam logic [15:0] CFG_RESET    = 16'h0000;
	localparam logic [7:0]  ROUTE_RESET  = 8'he4;
	localparam logic [15:0] STATUS_UNUSED = 16'h0000;

	typedef enum logic [1:0] {
		MODE_CONTINUOUS,
		MODE_GATED,
		MODE_INTERPOLATED,
		MODE_MULTIPLEXED
	} capture_mode_t;

	typedef enum logic [1:0] {
		FMT_FIXED,
		FMT_FLOAT_14_3,
		FMT_FLOAT_15_2,
		FMT_FLOAT_16_1
	} sample_format_t;

	typedef struct packed {
		logic [15:0] mant;
		logic [3:0]  expo;
	} sample_t;

endpackage : input_format_pkg

// ==== hdl/input_capture.sv ====
// Synchroniser and edge-selected capture for one parallel sample bus
`timescale 1ns/1ps
`default_nettype none
module input_capture
	import input_format_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        sys_rst,
	input  wire logic        sample_clock,
	input  wire logic [16:0] sample_bus,
	input  wire logic        input_sample_enable_n,
	input  wire logic        use_own_clock,
	input  wire logic        falling_edge,
	output logic             capture_strobe,
	output logic [16:0]      captured_bus,
	output logic             captured_enable
);

	typedef struct packed {
		logic        clk_s1;
		logic        clk_s2;
		logic        clk_s3;
		logic [16:0] bus_s1;
		logic [16:0] bus_s2;
		logic        en_s1;
		logic        en_s2;
		logic        stb;
		logic [16:0] bus_q;
		logic        en_q;
	} capture_state_t;

	capture_state_t state;
	capture_state_t next_state;
	logic           edge_seen;

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_state        = state;
		next_state.clk_s1 = sample_clock;
		next_state.clk_s2 = state.clk_s1;
		next_state.clk_s3 = state.clk_s2;
		next_state.bus_s1 = sample_bus;
		next_state.bus_s2 = state.bus_s1;
		next_state.en_s1  = ~input_sample_enable_n;
		next_state.en_s2  = state.en_s1;
		// Edge found on the synchronised copy; one edge per processing cycle at most, so the input clock must run slower
		edge_seen = falling_edge ? (state.clk_s3 & ~state.clk_s2) : (~state.clk_s3 & state.clk_s2);
		// Own input clock edge, or every rising processing clock edge
		next_state.stb   = use_own_clock ? edge_seen : 1'b1;
		next_state.bus_q = state.bus_s2;
		next_state.en_q  = state.en_s2;
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign capture_strobe  = state.stb;
	assign captured_bus    = state.bus_q;
	assign captured_enable = state.en_q;

endmodule : input_capture
`default_nettype wire

// ==== hdl/adc_input_select_format.sv ====
// Four-bus input select and format stage with register port and channel routing
//
// Overview of operation
// - Every register of the block runs on the rising edge of the processing clock.
// - Each bus captures on rising or falling edge of own clock, or on every rising processing clock edge.
// - Samples decode as fixed point or floating 14/3, 15/2, 16/1.
// - Floating exponent from pins is added to the range-control exponent.
// - Configuration bit 3 ignores exponent pins, leaving range exponent only.
// - Per-input choice of two's complement or offset binary in every format.
// - Gated mode processes one sample per clock with enable low, none otherwise.
// - The enable is pipelined beside its data instead of stalling.
// - Interpolated mode zeroes the sample when enable is high, output every clock.
// - Multiplexed mode picks one channel out of up to eight.
// - Enable delayed by programmable 0 to 7 clocks loads the selection register.
// - Undelayed enable loads the next register, realigning the selected channel.
// - Delay N selects frame position N+1; zero selects the first channel.
// - Configuration bit 4 reverses the bit order of that input bus.
// - Four independent 17-bit sample input buses.
// - Each bus can feed any one or more of the four channels.
// - Each bus has its own input clock.
//
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module adc_input_select_format
	import input_format_pkg::*;
(
	input  wire logic                    clock,
	input  wire logic                    sys_rst,
	input  wire logic [3:0]              sample_clock,
	input  wire logic [3:0][16:0]        sample_bus,
	input  wire logic [3:0]              input_sample_enable_n,
	input  wire logic [2:0]              address,
	input  wire logic [15:0]             write_data,
	input  wire logic                    write_strobe,
	input  wire logic                    read_strobe,
	output logic      [15:0]             read_data,
	output logic      [3:0][15:0]        channel_mantissa,
	output logic      [3:0][3:0]         channel_exponent,
	output logic      [3:0]              channel_valid
);

	typedef struct packed {
		logic [3:0][15:0] cfg;
		logic [7:0]       route;
		logic [15:0]      rdata;
		logic [3:0][7:0]  dly;
		sample_t [3:0]    sel;
		sample_t [3:0]    sec;
		logic [3:0]       sec_valid;
		sample_t [3:0]    chan;
		logic [3:0]       chan_valid;
	} block_state_t;

	block_state_t     state;
	block_state_t     next_state;
	logic [3:0]       cap_stb;
	logic [3:0][16:0] cap_bus;
	logic [3:0]       cap_en;

	////////////////////////////////////////////////////////////////////////////
	// Format decoding

	function automatic logic [16:0] reverse_bus(input logic [16:0] raw);
		logic [16:0] flipped;
		flipped = '0;
		for (int i = 0; i < 17; i++) begin
			flipped[i] = raw[16 - i];
		end
		return flipped;
	endfunction : reverse_bus

	function automatic sample_t decode_sample(input logic [16:0] raw, input logic [15:0] cfg);
		logic [16:0]    b;
		logic [15:0]    m;
		logic [2:0]     e;
		logic [2:0]     range_exp;
		sample_format_t fmt;
		sample_t        d;
		b         = cfg[REV_BIT] ? reverse_bus(raw) : raw;
		fmt       = sample_format_t'(cfg[FMT_LSB +: 2]);
		range_exp = cfg[RANGE_LSB +: 3];
		// Mantissa is always left aligned so downstream gain does not depend on format
		case (fmt)
			FMT_FIXED: begin
				m = b[16:1];
				e = 3'h0;
			end
			FMT_FLOAT_14_3: begin
				m = {b[16:3], 2'h0};
				e = b[2:0];
			end
			FMT_FLOAT_15_2: begin
				m = {b[16:2], 1'h0};
				e = {1'h0, b[1:0]};
			end
			FMT_FLOAT_16_1: begin
				m = b[16:1];
				e = {2'h0, b[0]};
			end
			default: begin
				m = b[16:1];
				e = 3'h0;
			end
		endcase
		if (cfg[OFFBIN_BIT]) begin
			m[15] = ~m[15];
		end
		if (cfg[IGNEXP_BIT]) begin
			e = 3'h0;
		end
		d.mant = m;
		if (fmt == FMT_FIXED) begin
			d.expo = 4'h0;
		end else begin
			d.expo = {1'h0, e} + {1'h0, range_exp};
		end
		return d;
	endfunction : decode_sample

	function automatic logic delayed_enable(input logic now, input logic [7:0] line, input logic [2:0] n);
		logic tap;
		tap = now;
		if (n != 3'h0) begin
			tap = line[3'(n - 3'h1)];
		end
		return tap;
	endfunction : delayed_enable

	////////////////////////////////////////////////////////////////////////////
	// One capture stage per bus, each on its own input clock or on every processing clock

	for (genvar g = 0; g < NUM_INPUTS; g++) begin : g_capture
		input_capture u_capture (
			.clock                 (clock),
			.sys_rst               (sys_rst),
			.sample_clock          (sample_clock[g]),
			.sample_bus            (sample_bus[g]),
			.input_sample_enable_n (input_sample_enable_n[g]),
			.use_own_clock         (state.cfg[g][OWNCLK_BIT]),
			.falling_edge          (state.cfg[g][FALL_BIT]),
			.capture_strobe        (cap_stb[g]),
			.captured_bus          (cap_bus[g]),
			.captured_enable       (cap_en[g])
		);
	end

	////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		capture_mode_t mode;
		sample_t       dec;
		logic          tap;
		logic [1:0]    src;
		mode       = MODE_CONTINUOUS;
		dec        = '0;
		tap        = 1'b0;
		src        = 2'h0;
		next_state = state;

		// Register writes
		if (write_strobe) begin
			case (address)
				CFG_A_OFFSET, CFG_B_OFFSET, CFG_C_OFFSET, CFG_D_OFFSET: begin
					next_state.cfg[address[1:0]] = write_data;
				end
				ROUTE_OFFSET: begin
					next_state.route = write_data[7:0];
				end
				default: begin
				end
			endcase
		end

		// Read data stands only in the cycle after the strobe
		next_state.rdata = 16'h0000;
		if (read_strobe) begin
			case (address)
				CFG_A_OFFSET, CFG_B_OFFSET, CFG_C_OFFSET, CFG_D_OFFSET: begin
					next_state.rdata = state.cfg[address[1:0]];
				end
				ROUTE_OFFSET: begin
					next_state.rdata = {8'h00, state.route};
				end
				STATUS_OFFSET: begin
					next_state.rdata = {STATUS_UNUSED[15:8], cap_en, state.sec_valid};
				end
				default: begin
					next_state.rdata = 16'h0000;
				end
			endcase
		end

		// Per-input mode handling
		for (int i = 0; i < NUM_INPUTS; i++) begin
			mode = capture_mode_t'(state.cfg[i][MODE_LSB +: 2]);
			dec  = decode_sample(cap_bus[i], state.cfg[i]);
			tap  = delayed_enable(cap_en[i], state.dly[i], state.cfg[i][DELAY_LSB +: 3]);
			next_state.sec_valid[i] = 1'b0;
			if (cap_stb[i]) begin
				next_state.dly[i] = {state.dly[i][6:0], cap_en[i]};
				case (mode)
					MODE_CONTINUOUS: begin
						next_state.sec[i]       = dec;
						next_state.sec_valid[i] = 1'b1;
					end
					MODE_GATED: begin
						// Valid flag rides with the word, nothing upstream stalls
						if (cap_en[i]) begin
							next_state.sec[i] = dec;
						end
						next_state.sec_valid[i] = cap_en[i];
					end
					MODE_INTERPOLATED: begin
						// Spacing of enables is the source's job; no check for it here
						next_state.sec[i]       = cap_en[i] ? dec : '0;
						next_state.sec_valid[i] = 1'b1;
					end
					MODE_MULTIPLEXED: begin
						// Frame start pulse marks channel one
						if (tap) begin
							next_state.sel[i] = dec;
						end
						// Output shows the previous frame's pick, one frame of latency
						if (cap_en[i]) begin
							next_state.sec[i] = state.sel[i];
						end
						next_state.sec_valid[i] = cap_en[i];
					end
					default: begin
						next_state.sec_valid[i] = 1'b0;
					end
				endcase
			end
		end

		// Channel routing: one bus may feed several channels
		for (int k = 0; k < NUM_INPUTS; k++) begin
			src                      = state.route[2*k +: 2];
			next_state.chan[k]       = state.sec[src];
			next_state.chan_valid[k] = state.sec_valid[src];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State register on the processing clock

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state            <= '0;
			state.cfg        <= {NUM_INPUTS{CFG_RESET}};
			state.route      <= ROUTE_RESET;
		end else begin
			state <= next_state;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs straight from the state register

	assign read_data     = state.rdata;
	assign channel_valid = state.chan_valid;

	for (genvar k = 0; k < NUM_INPUTS; k++) begin : g_out
		assign channel_mantissa[k] = state.chan[k].mant;
		assign channel_exponent[k] = state.chan[k].expo;
	end

endmodule : adc_input_select_format
`default_nettype wire

// ==== verification/input_format_properties.sv ====
// Concurrent checks on channel 0 while it is fed by bus 0 on the processing clock
`timescale 1ns/1ps
`default_nettype none
module input_format_properties
	import input_format_pkg::*;
(
	input wire logic             clock,
	input wire logic             sys_rst,
	input wire logic [3:0][16:0] sample_bus,
	input wire logic [3:0]       input_sample_enable_n,
	input wire logic [2:0]       address,
	input wire logic [15:0]      write_data,
	input wire logic             write_strobe,
	input wire logic [3:0][15:0] channel_mantissa,
	input wire logic [3:0][3:0]  channel_exponent,
	input wire logic [3:0]       channel_valid
);
	logic [15:0] cfg;
	logic [3:0]  settle;
	wire         quiet = settle == 4'h8;
	// Checks wait after a setup write, since samples in flight may mix old and new setup
	always_ff @(posedge clock) begin
		if (sys_rst || (write_strobe && address == CFG_A_OFFSET)) begin
			cfg    <= sys_rst ? 16'h0000 : write_data;
			settle <= 4'h0;
		end else if (!quiet) begin
			settle <= settle + 4'h1;
		end
	end
	////////////////////////////////////////
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	sequence in_mode(logic [1:0] m);
		quiet && cfg[9:8] == m && !cfg[1];
	endsequence
	cont_valid_a: assert property (in_mode(MODE_CONTINUOUS) |-> channel_valid[0])
		else $error("continuous sample missing");
	gated_valid_a: assert property (in_mode(MODE_GATED) |->
		channel_valid[0] == !$past(input_sample_enable_n[0], 5)) else $error("gated valid wrong");
	interp_zero_a: assert property (in_mode(MODE_INTERPOLATED) |-> channel_valid[0] &&
		(!$past(input_sample_enable_n[0], 5) || channel_mantissa[0] == 16'h0000 && channel_exponent[0] == 4'h0))
		else $error("interpolated sample wrong");
	mux_valid_a: assert property (quiet && cfg[9:8] == MODE_MULTIPLEXED && channel_valid[0] |->
		!$past(input_sample_enable_n[0], 5)) else $error("multiplexed valid off frame");
	hold_data_a: assert property (quiet && !channel_valid[0] |->
		$stable(channel_mantissa[0]) && $stable(channel_exponent[0])) else $error("data moved without valid");
	fixed_exp_a: assert property (quiet && cfg[7:6] == FMT_FIXED && channel_valid[0] |->
		channel_exponent[0] == 4'h0) else $error("fixed exponent not zero");
	ignore_exp_a: assert property (quiet && cfg[3] && cfg[7:6] != FMT_FIXED && cfg[9:8] != MODE_INTERPOLATED
		&& channel_valid[0] |-> channel_exponent[0] == {1'b0, cfg[15:13]}) else $error("exponent pins used");
	fixed_data_a: assert property (quiet && !cfg[9] && !cfg[1] && !cfg[4] && cfg[7:6] == FMT_FIXED
		&& channel_valid[0] |-> channel_mantissa[0] == ($past(sample_bus[0][16:1], 5) ^ {cfg[5], 15'h0000}))
		else $error("fixed mantissa wrong");
endmodule : input_format_properties
bind adc_input_select_format input_format_properties i_props (.clock(clock), .sys_rst(sys_rst),
	.sample_bus(sample_bus), .input_sample_enable_n(input_sample_enable_n), .address(address),
	.write_data(write_data), .write_strobe(write_strobe), .channel_mantissa(channel_mantissa),
	.channel_exponent(channel_exponent), .channel_valid(channel_valid));
`default_nettype wire

// ==== verification/adc_source.sv ====
// Behavioural converter that drives one sample bus from its own clock
`timescale 1ns/1ps
`default_nettype none
module adc_source (
	input  wire logic   sample_clock,
	output var logic [16:0] word = 17'h00000,
	output logic        enable_n
);
	// Word moves on the falling edge so it is steady around a rising capture edge
	always @(negedge sample_clock) word <= word + 17'h01011;
	assign enable_n = 1'b0;
endmodule : adc_source
`default_nettype wire

// ==== verification/adc_input_select_format_bench.sv ====
// Self-checking bench: register port, capture modes, formats, routing and own-clock capture
`timescale 1ns/1ps
`default_nettype none
module adc_input_select_format_bench import input_format_pkg::*;;
	logic clock = 1'b0, sys_rst = 1'b1, link_clock = 1'b0, en_n = 1'b1, watch = 1'b0, rd_d = 1'b0;
	logic write_strobe = 1'b0, read_strobe = 1'b0, adc_en_n;
	logic [2:0]       address = 3'h0;
	logic [15:0]      write_data = 16'h0000, read_data, cfg;
	logic [16:0]      word = 17'h00000, adc_word, nw;
	logic [31:0]      seed = 32'd62;
	logic [3:0][15:0] channel_mantissa;
	logic [3:0][3:0]  channel_exponent;
	logic [3:0]       channel_valid;
	logic [20:0]      q[4][$], x, e;
	logic [15:0]      rq[$];
	int               n_errors = 0, checked = 0, cnt;
	always #5 clock = ~clock;
	always #40 link_clock = ~link_clock;
	adc_input_select_format i_dut (.clock(clock), .sys_rst(sys_rst), .sample_clock({4{link_clock}}),
		.sample_bus({word, word, adc_word, word}), .input_sample_enable_n({en_n, en_n, adc_en_n, en_n}),
		.address(address), .write_data(write_data), .write_strobe(write_strobe), .read_strobe(read_strobe),
		.read_data(read_data), .channel_mantissa(channel_mantissa), .channel_exponent(channel_exponent),
		.channel_valid(channel_valid));
	adc_source i_adc (.sample_clock(link_clock), .word(adc_word), .enable_n(adc_en_n));
	////////////////////////////////////////
	function automatic logic [16:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[16:0];
	endfunction : rnd
	function automatic logic [20:0] decode(input logic [16:0] b, input logic [15:0] c);
		logic [16:0] r;
		logic [15:0] m;
		logic [3:0]  x4;
		r = b;
		if (c[4]) r = {<<{b}};
		case (c[7:6])
			2'd0: {m, x4} = {r[16:1], 4'h0};
			2'd1: {m, x4} = {r[16:3], 2'b00, 1'b0, r[2:0]};
			2'd2: {m, x4} = {r[16:2], 1'b0, 2'b00, r[1:0]};
			default: {m, x4} = {r[16:1], 3'b000, r[0]};
		endcase
		if (c[7:6] != 2'd0) x4 = (c[3] ? 4'h0 : x4) + {1'b0, c[15:13]};
		return {1'b0, m ^ {c[5], 15'h0000}, x4};
	endfunction : decode
	task automatic check(input string what, input logic [20:0] seen, input logic [20:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic end_sim();
		$display("checks %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : end_sim
	////////////////////////////////////////
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		address <= a;
		write_data <= d;
		write_strobe <= 1'b1;
		@(posedge clock);
		write_strobe <= 1'b0;
		@(posedge clock);
	endtask : wr
	task automatic rd(input logic [2:0] a, input logic [15:0] d);
		rq.push_back(d);
		address <= a;
		read_strobe <= 1'b1;
		@(posedge clock);
		read_strobe <= 1'b0;
		@(posedge clock);
	endtask : rd
	task automatic push(input logic [20:0] v);
		q[0].push_back(v);
		q[2].push_back(v);
	endtask : push
	task automatic drive(input logic [16:0] w, input logic hi);
		word <= w;
		en_n <= hi;
		@(posedge clock);
	endtask : drive
	task automatic step(input logic lo);
		nw = rnd();
		if (lo || cfg[9:8] == MODE_INTERPOLATED) push(lo ? decode(nw, cfg) : 21'h000000);
		drive(nw, !lo);
	endtask : step
	task automatic setup(input logic [15:0] c);
		if (watch && cfg[9:8] != MODE_INTERPOLATED) check("pending", 21'(q[0].size()), 21'h0);
		watch <= 1'b0;
		wr(CFG_A_OFFSET, c);
		rd(CFG_A_OFFSET, c);
		cfg = c;
		repeat (8) @(posedge clock);
		q[0].delete();
		q[2].delete();
		// Zero samples already in the pipeline come out first
		if (c[9:8] == MODE_INTERPOLATED) repeat (5) push(21'h000000);
		watch <= 1'b1;
	endtask : setup
	////////////////////////////////////////
	always @(posedge clock) begin
		rd_d <= read_strobe;
		if (rd_d) check("read data", {5'h00, read_data}, {5'h00, rq.pop_front()});
		for (int k = 0; k < 4; k += 2) begin
			if (watch && channel_valid[k]) begin
				e = q[k].size() ? q[k].pop_front() : 21'h0fffff;
				if (!e[20]) check("channel", {1'b0, channel_mantissa[k], channel_exponent[k]}, e);
			end
		end
	end
	initial begin
		repeat (5000) @(posedge clock);
		n_errors++;
		end_sim();
	end
	initial begin
		repeat (3) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		for (int a = 0; a < 4; a++) rd(3'(a), CFG_RESET);
		rd(ROUTE_OFFSET, {8'h00, ROUTE_RESET});
		// Status: bus 1 enable low, every section valid in continuous mode after reset
		rd(STATUS_OFFSET, 16'h002f);
		wr(3'h7, 16'hffff);
		rd(3'h7, 16'h0000);
		wr(ROUTE_OFFSET, 16'h00c4);
		rd(ROUTE_OFFSET, 16'h00c4);
		for (int i = 0; i < 8; i++) begin
			nw = rnd();
			setup({nw[15:13], 3'h0, i[0] ? MODE_INTERPOLATED : MODE_GATED, i[2:1], nw[5], i[2], i[1], 2'b00, nw[0]});
			for (int j = 0; j < 40; j++) begin
				nw = rnd();
				step(i[0] ? (j % 3 == 0) : nw[0]);
			end
			repeat (8) step(1'b0);
		end
		for (int n = 0; n < 8; n++) begin
			setup({3'h0, n[2:0], MODE_MULTIPLEXED, 8'h00});
			x = 21'h100000;
			for (int w = 0; w < 25; w++) begin
				nw = rnd();
				if (w % 8 == 0) push(x);
				if (w % 8 == n) x = {1'b0, nw[16:1], 4'h0};
				drive(nw, w % 8 != 0);
			end
			repeat (8) drive(nw, 1'b1);
		end
		setup(16'h0100);
		@(posedge clock);
		// Channel 0 runs continuous here so its checker properties see that mode
		watch <= 1'b0;
		wr(CFG_A_OFFSET, 16'h0000);
		for (int c = 0; c < 3; c++) begin
			wr(CFG_B_OFFSET, c == 0 ? 16'h0000 : 16'(c + 1));
			repeat (16) @(posedge clock);
			cnt = 0;
			repeat (80) begin
				@(negedge clock);
				cnt += channel_valid[1];
			end
			check("own clock samples", 21'(cnt), c == 0 ? 21'd80 : 21'd10);
			@(posedge clock);
		end
		end_sim();
	end
endmodule : adc_input_select_format_bench
`default_nettype wire
